// ===== verification/adc_sweep_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcss_regs.svh"
module adc_sweep_sequencer_tb_top;
	import adcss_pkg::*;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	adcss_word_t reg_wdata = 32'h0;
	adcss_word_t reg_rdata;
	logic reg_rvalid;
	logic mod_bit;
	logic mod_reset;
	logic [4:0] mux_sel;
	logic busy;
	logic conv_irq;
	logic [1:0] mod_mode = 2'd0;
	int num_errors = 0;
	int checked = 0;
	int cnt;
	adcss_word_t rd_q;
	logic [4:0] top_sel;
	adcss_word_t ovr_tim [4] = '{32'h000A3F00, 32'h000A3F00, 32'h000A3A00, 32'h000A4000};
	adcss_word_t ovr_exp [4] = '{32'h008047FF, 32'h00804800, 32'h010047FF, 32'h00000040};
	logic [1:0] ovr_mode [4] = '{2'd1, 2'd2, 2'd1, 2'd1};

	always #2.5 sys_clk = ~sys_clk;

	adcss_top DUT (
		.i_sys_clk(sys_clk),
		.i_srst(srst),
		.i_reg_wr(reg_wr),
		.i_reg_rd(reg_rd),
		.i_reg_addr(reg_addr),
		.i_reg_wdata(reg_wdata),
		.o_reg_rdata(reg_rdata),
		.o_reg_rvalid(reg_rvalid),
		.i_mod_bit(mod_bit),
		.o_mod_reset(mod_reset),
		.o_mux_sel(mux_sel),
		.o_busy(busy),
		.o_conv_irq(conv_irq)
	);

	adcss_mod_model model (
		.i_sys_clk(sys_clk),
		.i_mod_reset(mod_reset),
		.i_mode(mod_mode),
		.o_mod_bit(mod_bit)
	);

	task automatic check(input adcss_word_t seen, input adcss_word_t exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %08X expected %08X", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : complete_run

	// Strobes stay up between back-to-back accesses; any idle wait drops them first
	task automatic tick(input int n);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick

	task automatic wr(input logic [7:0] a, input adcss_word_t d);
		reg_rd = 1'b0;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge sys_clk);
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		reg_wr = 1'b0;
		reg_rd = 1'b1;
		reg_addr = a;
		@(posedge sys_clk);
		#1;
		rd_q = reg_rdata;
	endtask : rd

	// Whole setup goes in before any trigger, enables last
	task automatic setup(input adcss_word_t tim, input adcss_word_t en, input adcss_word_t fsel);
		wr(`ADCSS_OFF_CFG_A, 32'h00002000);
		wr(`ADCSS_OFF_SE_CFG, fsel);
		wr(`ADCSS_OFF_TIMING, tim);
		wr(`ADCSS_OFF_STAB, 32'h00005FF0);
		wr(`ADCSS_OFF_SEQ, en);
		tick(4);
	endtask : setup

	task automatic sweep();
		cnt = 0;
		top_sel = 5'h00;
		wr(`ADCSS_OFF_CFG_B, 32'h1);
		for (int i = 0; i < 3000 && (cnt == 0 || busy === 1'b1); i++) begin
			if (busy === 1'b1) begin
				cnt++;
				if (mux_sel > top_sel) top_sel = mux_sel;
			end
			tick(1);
		end
	endtask : sweep

	task automatic wait_done();
		rd_q = 32'h0;
		for (int i = 0; i < 200 && rd_q[`ADCSS_I_DONE] !== 1'b1; i++) rd(`ADCSS_OFF_INT_STAT);
	endtask : wait_done

	task automatic t_reset();
		rd(`ADCSS_OFF_DATA);
		check(rd_q, 32'h0000C000);
		check(32'(reg_rvalid), 32'h1);
		tick(1);
		check(32'(reg_rvalid), 32'h0);
		rd(8'hFC);
		check(rd_q, 32'h0);
		rd(`ADCSS_OFF_INT_STAT);
		check(rd_q, 32'h0);
	endtask : t_reset

	task automatic t_single();
		mod_mode = 2'd0;
		setup(32'h00000402, 32'h0, 32'h0);
		wr(`ADCSS_OFF_CFG_B, 32'h1);
		tick(3);
		check(32'(busy), 32'h0);
		wr(`ADCSS_OFF_SEQ, 32'h5);
		tick(4);
		sweep();
		check(32'(cnt), 32'd108);
		check(32'(top_sel), 32'h2);
		tick(4);
		check(32'(conv_irq), 32'h1);
		rd(`ADCSS_OFF_DATA + 8'h04);
		check(rd_q, 32'h0000C000);
		check(32'(conv_irq), 32'h0);
		wait_done();
		check(rd_q & 32'h80000005, 32'h80000005);
		rd(`ADCSS_OFF_DATA);
		check(rd_q, 32'h0);
		rd(`ADCSS_OFF_DATA + 8'h08);
		check(rd_q, 32'h0);
		rd(`ADCSS_OFF_DATA);
		check(rd_q, 32'h0000C000);
		tick(20);
		check(32'(busy), 32'h0);
	endtask : t_single

	task automatic t_ovr();
		for (int i = 0; i < 4; i++) begin
			mod_mode = ovr_mode[i];
			setup(ovr_tim[i], 32'h1, (i == 2) ? 32'h1 : 32'h0);
			sweep();
			wait_done();
			rd(`ADCSS_OFF_DATA);
			check(rd_q, ovr_exp[i]);
		end
	endtask : t_ovr

	task automatic t_overload();
		mod_mode = 2'd1;
		setup(32'h00004000, 32'h1, 32'h0);
		wr(`ADCSS_OFF_STAB, 32'h00005080);
		wr(`ADCSS_OFF_CFG_B, 32'h1);
		for (int i = 0; i < 200 && mod_reset !== 1'b1; i++) tick(1);
		cnt = 0;
		for (int i = 0; i < 100 && mod_reset === 1'b1; i++) begin
			cnt++;
			tick(1);
		end
		check(32'(cnt), 32'd5);
		wait_done();
		rd(`ADCSS_OFF_STAB);
		check(rd_q & 32'h1, 32'h1);
		rd(`ADCSS_OFF_DATA);
		check(rd_q & 32'h0200C000, 32'h02004000);
		rd(`ADCSS_OFF_DATA);
		check(rd_q & 32'h02000000, 32'h02000000);
		wr(`ADCSS_OFF_STAB, 32'h00005081);
		rd(`ADCSS_OFF_DATA);
		check(rd_q & 32'h02000000, 32'h0);
	endtask : t_overload

	task automatic t_overlap();
		mod_mode = 2'd0;
		setup(32'h00004000, 32'h1, 32'h0);
		wr(`ADCSS_OFF_CFG_B, 32'h1);
		tick(10);
		wr(`ADCSS_OFF_CFG_B, 32'h1);
		tick(60);
		check(32'(busy), 32'h1);
		wait_done();
		rd(`ADCSS_OFF_DATA);
		check(rd_q & 32'h04004000, 32'h04004000);
		sweep();
		check(32'(cnt), 32'd64);
		wait_done();
		rd(`ADCSS_OFF_DATA);
		check(rd_q & 32'h04000000, 32'h0);
	endtask : t_overlap

	task automatic t_cont();
		setup(32'h00004000, 32'h1, 32'h0);
		wr(`ADCSS_OFF_CFG_A, 32'h0);
		wr(`ADCSS_OFF_CFG_B, 32'h1);
		tick(138);
		check(32'(busy), 32'h1);
		wr(`ADCSS_OFF_CFG_B, 32'h2);
		cnt = 0;
		for (int i = 0; i < 200 && busy === 1'b1; i++) begin
			cnt++;
			tick(1);
		end
		// Halting mid-sweep must let the running sweep finish, and no further one
		check(32'(cnt > 30 && cnt < 64), 32'h1);
		wait_done();
		tick(20);
		check(32'(busy), 32'h0);
	endtask : t_cont

	initial begin
		repeat (8) @(posedge sys_clk);
		#1;
		srst = 1'b0;
		t_reset();
		t_single();
		t_ovr();
		t_overload();
		t_overlap();
		t_cont();
		complete_run();
	end

	// The whole run needs about a thousand cycles; this span is some forty times that
	initial begin
		#200000;
		num_errors++;
		complete_run();
	end
endmodule : adc_sweep_sequencer_tb_top
`default_nettype wire

// ===== verification/adcss_mod_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcss_mod_model (
	input wire logic i_sys_clk,
	input wire logic i_mod_reset,
	input wire logic [1:0] i_mode,
	output logic o_mod_bit
);
	logic toggle_q = 1'b0;

	always_ff @(posedge i_sys_clk) begin
		toggle_q <= ~toggle_q;
	end

	// A modulator held in reset only chatters, so no run builds up there
	always_comb begin
		case (i_mode)
			2'd1: o_mod_bit = i_mod_reset ? toggle_q : 1'b1;
			2'd2: o_mod_bit = i_mod_reset ? toggle_q : 1'b0;
			default: o_mod_bit = toggle_q;
		endcase
	end
endmodule : adcss_mod_model
`default_nettype wire

// ===== verilog/adcss_buf.sv
`timescale 1ns/1ps
`default_nettype none
module adcss_buf #(
	parameter int W = 19
) (
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [W-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [W-1:0] o_data
);
	logic [W-1:0] mem_q [2];
	logic wr_q;
	logic rd_q;
	logic [1:0] cnt_q;
	wire push = i_valid && o_ready;
	wire pop = o_valid && i_ready;

	assign o_ready = cnt_q != 2'h2;
	assign o_valid = cnt_q != 2'h0;
	assign o_data = mem_q[rd_q];

	always_ff @(posedge i_sys_clk) begin
		if (push) begin
			mem_q[wr_q] <= i_data;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			if (push) wr_q <= ~wr_q;
			if (pop) rd_q <= ~rd_q;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule : adcss_buf
`default_nettype wire

// ===== verilog/adcss_pkg.sv
`default_nettype none
package adcss_pkg;

	typedef logic [31:0] adcss_word_t;

	typedef enum logic [1:0] {
		ADCSS_IDLE = 2'b00,
		ADCSS_SETTLE = 2'b01,
		ADCSS_CONV = 2'b10,
		ADCSS_WAIT = 2'b11
	} adcss_state_e;

	typedef logic [7:0] adcss_osr_t;

	localparam adcss_osr_t ADCSS_OSR_CUBIC [7] = '{8'h3F, 8'h50, 8'h65, 8'h7F, 8'hA0, 8'hCA, 8'hFF};
	localparam adcss_osr_t ADCSS_OSR_QUART [9] = '{8'h3A, 8'h45, 8'h52, 8'h62, 8'h74, 8'h8A, 8'hA4,
		8'hC3, 8'hE8};

	function automatic logic adcss_osr_ok(input adcss_osr_t oversampling_ratio, input logic quartic);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 7; i++) begin
			if (!quartic && oversampling_ratio == ADCSS_OSR_CUBIC[i]) hit = 1'b1;
		end
		for (int i = 0; i < 9; i++) begin
			if (quartic && oversampling_ratio == ADCSS_OSR_QUART[i]) hit = 1'b1;
		end
		return hit;
	endfunction : adcss_osr_ok

endpackage : adcss_pkg
`default_nettype wire

// ===== verilog/adcss_regs.svh
`ifndef ADCSS_REGS_SVH
`define ADCSS_REGS_SVH

// Register byte offsets
`define ADCSS_OFF_CFG_A 8'h00
`define ADCSS_OFF_CFG_B 8'h04
`define ADCSS_OFF_SE_CFG 8'h10
`define ADCSS_OFF_TIMING 8'h74
`define ADCSS_OFF_SEQ 8'h78
`define ADCSS_OFF_STAB 8'h84
`define ADCSS_OFF_INT_STAT 8'h8C
`define ADCSS_OFF_DATA 8'h90
`define ADCSS_OFF_DATA_LAST 8'hD4

// Channel count covered by the result words
`define ADCSS_N_CH 18

// converter_config_a
`define ADCSS_A_SINGLE 13
// converter_config_b
`define ADCSS_B_TRIG 0
`define ADCSS_B_HALT 1
`define ADCSS_B_DONE 2
// timing_control fields
`define ADCSS_T_SETTLE_LSB 0
`define ADCSS_T_OSR_LSB 8
`define ADCSS_T_FS_LSB 16
// stability_control fields
`define ADCSS_S_OVL 0
`define ADCSS_S_LIM_LSB 4
`define ADCSS_S_REC_LSB 12
// interrupt_status
`define ADCSS_I_DONE 31
// channel_result_word fields
`define ADCSS_D_ANY_ERR 14
`define ADCSS_D_STALE 15
`define ADCSS_D_CUBIC_OVR 23
`define ADCSS_D_QUART_OVR 24
`define ADCSS_D_OVL 25
`define ADCSS_D_TRIG_OVL 26

// Timing and code limits
`define ADCSS_SETTLE_MULT 16'd25
`define ADCSS_FS_MAX 11'h7FF
`define ADCSS_CODE_MAX 12'h7FF
`define ADCSS_CODE_MIN 12'h800

`endif

// ===== verilog/adcss_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcss_regs.svh"

// Notes on behaviour
// [R01] Per channel: settle count times 25 cycles plus oversampling ratio cycles.
// [R02] Bit 14 of each result word is the OR of all other error flags.
// [R03] Bit 15 marks a stale result: none since reset or since last read.
// [R04] Filter overrange flag (bit 23 cubic, 24 quartic) sets on out-of-scale density.
// [R05] Non-recommended oversampling ratio forces full-scale limit 0x7FF.
// [R06] Overload flag sets when bitstream repeats beyond limit; bit 25 mirrors it.
// [R07] Overload resets modulator for recovery cycles; filter data stays undisturbed.
// [R08] Mirrored overload bit clears only when software clears the source flag.
// [R09] Trigger during conversion sets overlap flag (bit 26) and restarts conversion.
// [R10] A fresh trigger starting a conversion clears the overlap flag.
// [R11] Result words sit at consecutive word offsets 0x90 through 0xD4.
// [R12] Trigger bit starts conversions in single-sweep and continuous mode.
// [R13] Software finishes a valid configuration before setting the trigger.
// [R14] Continuous mode keeps sweeping enabled channels until halted.
// [R15] Single-sweep mode does one sweep then waits for another trigger.
// [R16] Software polls highest channel done and combined done before reading.
// [R17] Continuous halt takes effect at the end of the current sweep.
// [R18] Software waits settling time before triggering after enable changes.
// [R19] Combined interrupt stays high until a result or status word is read.
// [R20] Combined done sets once the last channel's result is stored.
module adcss_top #(
	parameter int N_CH = `ADCSS_N_CH,
	parameter int CW = 5
) (
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire adcss_pkg::adcss_word_t i_reg_wdata,
	output adcss_pkg::adcss_word_t o_reg_rdata,
	output logic o_reg_rvalid,
	input wire logic i_mod_bit,
	output logic o_mod_reset,
	output logic [CW-1:0] o_mux_sel,
	output logic o_busy,
	output logic o_conv_irq
);
	import adcss_pkg::*;

	localparam int BW = CW + 14;

	// Configuration
	logic single_q;
	logic halt_q;
	logic [7:0] settle_q;
	logic [7:0] osr_q;
	logic [10:0] fs_q;
	logic [N_CH-1:0] en_q;
	logic [N_CH-1:0] filt_q;
	logic [7:0] ovl_lim_q;
	logic [7:0] ovl_rec_q;
	// Status
	logic ovl_q;
	logic trig_ovl_q;
	logic done_q;
	logic irq_q;
	logic [N_CH-1:0] chdone_q;
	logic [11:0] val_q [N_CH];
	logic [N_CH-1:0] cub_q;
	logic [N_CH-1:0] qua_q;
	logic [N_CH-1:0] stale_q;
	// Sequencer
	adcss_state_e st_q;
	logic [15:0] cnt_q;
	logic [CW-1:0] ch_q;
	logic signed [15:0] acc_q;
	logic [BW-1:0] pend_q;
	// Overload detector
	logic prev_q;
	logic [7:0] run_q;
	logic [7:0] rec_q;

	wire wr_a = i_reg_wr && i_reg_addr == `ADCSS_OFF_CFG_A;
	wire wr_b = i_reg_wr && i_reg_addr == `ADCSS_OFF_CFG_B;
	wire wr_stab = i_reg_wr && i_reg_addr == `ADCSS_OFF_STAB;
	wire busy = st_q != ADCSS_IDLE;
	wire trig = wr_b && i_reg_wdata[`ADCSS_B_TRIG];
	wire rd_data = i_reg_rd && i_reg_addr >= `ADCSS_OFF_DATA &&
		i_reg_addr <= `ADCSS_OFF_DATA_LAST && i_reg_addr[1:0] == 2'h0;
	wire [7:0] rd_off = i_reg_addr - `ADCSS_OFF_DATA;
	wire [CW-1:0] rd_idx = rd_off[CW+1:2];

	function automatic logic [CW:0] next_ch(input logic [N_CH-1:0] en, input logic [CW:0] from);
		logic [CW:0] r;
		r = '0;
		for (int i = N_CH - 1; i >= 0; i--) begin
			if (en[i] && CW'(i) >= from[CW-1:0] && !from[CW]) r = {1'b1, CW'(i)};
		end
		return r;
	endfunction : next_ch

	// Configuration writes
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			single_q <= 1'b0;
			settle_q <= '0;
			osr_q <= '0;
			fs_q <= '0;
			en_q <= '0;
			filt_q <= '0;
			ovl_lim_q <= '0;
			ovl_rec_q <= '0;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				`ADCSS_OFF_CFG_A: single_q <= i_reg_wdata[`ADCSS_A_SINGLE];
				`ADCSS_OFF_SE_CFG: filt_q <= i_reg_wdata[N_CH-1:0];
				`ADCSS_OFF_TIMING: begin
					settle_q <= i_reg_wdata[`ADCSS_T_SETTLE_LSB +: 8];
					osr_q <= i_reg_wdata[`ADCSS_T_OSR_LSB +: 8];
					fs_q <= i_reg_wdata[`ADCSS_T_FS_LSB +: 11];
				end
				`ADCSS_OFF_SEQ: en_q <= i_reg_wdata[N_CH-1:0];
				`ADCSS_OFF_STAB: begin
					ovl_lim_q <= i_reg_wdata[`ADCSS_S_LIM_LSB +: 8];
					ovl_rec_q <= i_reg_wdata[`ADCSS_S_REC_LSB +: 8];
				end
				default: ;
			endcase
		end
	end

	// Sequencer timing
	wire [CW:0] first = next_ch(en_q, '0);
	wire [CW:0] nxt = next_ch(en_q, {1'b0, ch_q} + 1'b1);
	wire [15:0] settle_cyc = 16'(16'(settle_q) * `ADCSS_SETTLE_MULT - 16'd1); // [R01]
	wire [15:0] osr_cyc = (osr_q == 8'h00) ? 16'h0000 : 16'(osr_q) - 16'd1; // [R01]
	wire adv_go = nxt[CW] || (!single_q && !halt_q && first[CW]); // [R14] [R15] [R17]
	wire [CW-1:0] adv_ch = nxt[CW] ? nxt[CW-1:0] : first[CW-1:0];
	wire conv_end = st_q == ADCSS_CONV && cnt_q == 16'h0000;
	logic buf_rdy;
	wire push_v = conv_end || st_q == ADCSS_WAIT;
	wire push_fire = push_v && buf_rdy;
	wire sweep_end = push_fire && !nxt[CW];

	// Filter result with overrange against the active full-scale limit
	wire cur_quart = filt_q[ch_q];
	wire signed [15:0] fin = acc_q + (i_mod_bit ? 16'sd1 : -16'sd1);
	wire osr_ok = adcss_osr_ok(osr_q, cur_quart);
	wire [10:0] lim = osr_ok ? fs_q : `ADCSS_FS_MAX; // [R05]
	wire signed [15:0] lim_s = signed'({5'h00, lim});
	wire ovr_hi = fin > lim_s; // [R04]
	wire ovr_lo = fin < -lim_s - 16'sd1; // [R04]
	wire [11:0] code = ovr_hi ? `ADCSS_CODE_MAX : (ovr_lo ? `ADCSS_CODE_MIN : fin[11:0]);
	wire [BW-1:0] res_new = {!nxt[CW], ovr_hi || ovr_lo, ch_q, code};
	wire [BW-1:0] push_d = conv_end ? res_new : pend_q;

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			st_q <= ADCSS_IDLE;
			cnt_q <= '0;
			ch_q <= '0;
		end else if (trig && first[CW]) begin // [R09] [R12]
			ch_q <= first[CW-1:0];
			st_q <= (settle_q == 8'h00) ? ADCSS_CONV : ADCSS_SETTLE;
			cnt_q <= (settle_q == 8'h00) ? osr_cyc : settle_cyc;
		end else begin
			case (st_q)
				ADCSS_SETTLE: begin
					if (cnt_q == 16'h0000) begin
						st_q <= ADCSS_CONV;
						cnt_q <= osr_cyc;
					end else begin
						cnt_q <= cnt_q - 16'd1;
					end
				end
				ADCSS_CONV, ADCSS_WAIT: begin
					if (st_q == ADCSS_CONV && cnt_q != 16'h0000) begin
						cnt_q <= cnt_q - 16'd1;
					end else if (!push_fire) begin
						st_q <= ADCSS_WAIT;
					end else if (adv_go) begin
						ch_q <= adv_ch;
						st_q <= (settle_q == 8'h00) ? ADCSS_CONV : ADCSS_SETTLE;
						cnt_q <= (settle_q == 8'h00) ? osr_cyc : settle_cyc;
					end else begin
						st_q <= ADCSS_IDLE;
					end
				end
				default: st_q <= ADCSS_IDLE;
			endcase
		end
	end

	// Accumulator only sees the bitstream, never the modulator reset
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			acc_q <= '0;
			pend_q <= '0;
		end else begin
			acc_q <= (st_q == ADCSS_CONV && !conv_end && !trig) ? fin : 16'sh0000; // [R07]
			if (conv_end) pend_q <= res_new;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			halt_q <= 1'b0;
			trig_ovl_q <= 1'b0;
		end else begin
			if (wr_b && i_reg_wdata[`ADCSS_B_HALT]) halt_q <= 1'b1; // [R17]
			else if (trig || (sweep_end && !adv_go)) halt_q <= 1'b0;
			if (trig && busy) trig_ovl_q <= 1'b1; // [R09]
			else if (trig) trig_ovl_q <= 1'b0; // [R10]
		end
	end

	// Stall draining only while a result word is read, so status polling never starves storing
	logic drain_v;
	logic [BW-1:0] drain_d;
	wire drain_fire = drain_v && !rd_data;
	wire [CW-1:0] drain_ch = drain_d[12 +: CW];

	adcss_buf #(.W(BW)) u_buf (
		.i_sys_clk(i_sys_clk),
		.i_srst(i_srst),
		.i_valid(push_v),
		.o_ready(buf_rdy),
		.i_data(push_d),
		.o_valid(drain_v),
		.i_ready(!rd_data),
		.o_data(drain_d)
	);

	genvar g;
	generate
		for (g = 0; g < N_CH; g++) begin : g_ch
			wire st_hit = drain_fire && drain_ch == CW'(g);
			always_ff @(posedge i_sys_clk) begin
				if (i_srst) begin
					val_q[g] <= '0;
					cub_q[g] <= 1'b0;
					qua_q[g] <= 1'b0;
					stale_q[g] <= 1'b1; // [R03]
					chdone_q[g] <= 1'b0;
				end else begin
					if (st_hit) begin
						val_q[g] <= drain_d[11:0];
						cub_q[g] <= drain_d[BW-2] && !filt_q[g]; // [R04]
						qua_q[g] <= drain_d[BW-2] && filt_q[g]; // [R04]
					end
					if (st_hit) stale_q[g] <= 1'b0;
					else if (rd_data && rd_idx == CW'(g)) stale_q[g] <= 1'b1; // [R03]
					if (st_hit) chdone_q[g] <= 1'b1;
					else if (trig) chdone_q[g] <= 1'b0;
				end
			end
		end
	endgenerate

	wire last_store = drain_fire && drain_d[BW-1];
	wire irq_clr = rd_data || (i_reg_rd && i_reg_addr == `ADCSS_OFF_INT_STAT);

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			done_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			if (last_store) done_q <= 1'b1; // [R20]
			else if (trig) done_q <= 1'b0;
			if (last_store) irq_q <= 1'b1; // [R19]
			else if (irq_clr) irq_q <= 1'b0;
		end
	end

	// Overload: a run of identical bits more than one bit longer than the limit
	// A run that is already past a newly lowered limit must still count as overload
	wire ovl_evt = busy && rec_q == 8'h00 && i_mod_bit == prev_q && run_q >= ovl_lim_q; // [R06]

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			prev_q <= 1'b0;
			run_q <= '0;
			rec_q <= '0;
			ovl_q <= 1'b0;
		end else begin
			prev_q <= i_mod_bit;
			if (rec_q != 8'h00 || i_mod_bit != prev_q || ovl_evt) run_q <= '0;
			else if (run_q != 8'hFF) run_q <= run_q + 8'd1;
			if (ovl_evt) rec_q <= ovl_rec_q; // [R07]
			else if (rec_q != 8'h00) rec_q <= rec_q - 8'd1;
			if (ovl_evt) ovl_q <= 1'b1; // [R06]
			else if (wr_stab && i_reg_wdata[`ADCSS_S_OVL]) ovl_q <= 1'b0; // [R08]
		end
	end

	// Read path
	adcss_word_t rd_w;
	always_comb begin
		rd_w = '0;
		case (i_reg_addr)
			`ADCSS_OFF_CFG_A: rd_w[`ADCSS_A_SINGLE] = single_q;
			`ADCSS_OFF_CFG_B: begin
				rd_w[`ADCSS_B_HALT] = halt_q;
				rd_w[`ADCSS_B_DONE] = done_q;
			end
			`ADCSS_OFF_SE_CFG: rd_w[N_CH-1:0] = filt_q;
			`ADCSS_OFF_TIMING: rd_w = {5'h00, fs_q, osr_q, settle_q};
			`ADCSS_OFF_SEQ: rd_w[N_CH-1:0] = en_q;
			`ADCSS_OFF_STAB: rd_w = {12'h000, ovl_rec_q, ovl_lim_q, 3'h0, ovl_q};
			`ADCSS_OFF_INT_STAT: begin
				rd_w[N_CH-1:0] = chdone_q;
				rd_w[`ADCSS_I_DONE] = done_q;
			end
			default: ;
		endcase
		if (rd_data) begin // [R11]
			rd_w[11:0] = val_q[rd_idx];
			rd_w[`ADCSS_D_STALE] = stale_q[rd_idx];
			rd_w[`ADCSS_D_CUBIC_OVR] = cub_q[rd_idx];
			rd_w[`ADCSS_D_QUART_OVR] = qua_q[rd_idx];
			rd_w[`ADCSS_D_OVL] = ovl_q; // [R06] [R08]
			rd_w[`ADCSS_D_TRIG_OVL] = trig_ovl_q;
			rd_w[`ADCSS_D_ANY_ERR] = rd_w[`ADCSS_D_STALE] | (|rd_w[26:23]); // [R02]
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_reg_rdata <= '0;
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rdata <= i_reg_rd ? rd_w : '0;
			o_reg_rvalid <= i_reg_rd;
		end
	end

	assign o_mod_reset = rec_q != 8'h00;
	assign o_mux_sel = ch_q;
	assign o_busy = busy;
	assign o_conv_irq = irq_q;

	// Checks
	logic rd_data_q;
	always_ff @(posedge i_sys_clk) rd_data_q <= !i_srst && rd_data;

	AST_ANY_ERR: assert property (@(posedge i_sys_clk) disable iff (i_srst) // [R02]
		o_reg_rvalid && rd_data_q |-> o_reg_rdata[14] == (o_reg_rdata[15] | (|o_reg_rdata[26:23])))
		else $error("any-error bit mismatch");
	AST_OVL_MIRROR: assert property (@(posedge i_sys_clk) disable iff (i_srst) // [R06]
		rd_data |=> o_reg_rdata[25] == $past(ovl_q))
		else $error("overload mirror mismatch");
	AST_OVL_STICKY: assert property (@(posedge i_sys_clk) disable iff (i_srst) // [R08]
		ovl_q && !wr_stab |=> ovl_q)
		else $error("overload flag dropped without software clear");
	AST_RECOVERY: assert property (@(posedge i_sys_clk) disable iff (i_srst) // [R07]
		ovl_evt && ovl_rec_q != 8'h00 |=> o_mod_reset && ovl_q)
		else $error("modulator not reset on overload");
	AST_TRIG_OVL: assert property (@(posedge i_sys_clk) disable iff (i_srst) // [R09]
		trig && busy && first[CW] |=> trig_ovl_q && busy &&
		cnt_q == $past((settle_q == 8'h00) ? osr_cyc : settle_cyc))
		else $error("overlap trigger not flagged or not restarted");
	AST_TRIG_FRESH: assert property (@(posedge i_sys_clk) disable iff (i_srst) // [R10]
		trig && !busy |=> !trig_ovl_q)
		else $error("fresh trigger did not clear overlap");
	AST_SINGLE_STOP: assert property (@(posedge i_sys_clk) disable iff (i_srst) // [R15]
		sweep_end && single_q && !trig |=> st_q == ADCSS_IDLE)
		else $error("single sweep did not stop");
	AST_CONT_RUN: assert property (@(posedge i_sys_clk) disable iff (i_srst) // [R14]
		sweep_end && !single_q && !halt_q && !trig |=> busy && ch_q == $past(first[CW-1:0]))
		else $error("continuous mode did not restart");
	AST_IRQ_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_srst) // [R19]
		o_conv_irq && !irq_clr |=> o_conv_irq)
		else $error("interrupt dropped early");
	AST_CONV_LEN: assert property (@(posedge i_sys_clk) disable iff (i_srst) // [R01]
		st_q == ADCSS_SETTLE && cnt_q == 16'h0000 && !trig |=> st_q == ADCSS_CONV && cnt_q == osr_cyc)
		else $error("conversion length wrong");
	AST_FULLSCALE: assert property (@(posedge i_sys_clk) disable iff (i_srst) // [R05]
		conv_end && !osr_ok |-> ovr_hi == (fin > 16'sh07FF) && ovr_lo == (fin < -16'sh0800))
		else $error("full-scale limit not forced");
	AST_DONE: assert property (@(posedge i_sys_clk) disable iff (i_srst) // [R20]
		last_store |=> done_q && o_conv_irq)
		else $error("combined done not set");

	COV_SINGLE: cover property (@(posedge i_sys_clk) disable iff (i_srst) sweep_end && single_q);
	COV_CONT: cover property (@(posedge i_sys_clk) disable iff (i_srst) sweep_end && !single_q ##1 busy);
	COV_OVERLAP: cover property (@(posedge i_sys_clk) disable iff (i_srst) trig && busy);
	COV_STALL: cover property (@(posedge i_sys_clk) disable iff (i_srst) st_q == ADCSS_WAIT);
endmodule : adcss_top
`default_nettype wire
